// ===== rtl/tsm_pkg.sv
// Constants for the thermal sensor monitor: offsets, fields, resets, timing
package tsm_pkg;
    // Register byte offsets on the configuration path
    localparam logic [11:0] OFF_EVT_MASK   = 12'h538;
    localparam logic [11:0] OFF_THR_STAT   = 12'h53C;
    localparam logic [11:0] OFF_TEST_CTRL  = 12'h5D4;
    localparam logic [11:0] OFF_CONV_CTRL  = 12'h5D8;

    // Threshold and status word
    localparam int THR_OVER_LSB  = 0;   // Over-threshold bits 2:0
    localparam int THR_FLD0_LSB  = 24;  // Sensor 0 threshold 25:24
    localparam int THR_FLD1_LSB  = 26;
    localparam int THR_FLD2_LSB  = 28;
    localparam int THR_AUTO_BIT  = 31;

    // Conversion control word
    localparam int CONV_BURST_BIT = 0;
    localparam int CONV_SINGLE_BIT = 1;
    localparam int CONV_PD_BIT    = 2;
    localparam int CONV_DATA_LSB  = 8;  // Result 19:8
    localparam int CONV_DONE_BIT  = 23;

    // Test control word
    localparam int TEST_ITEM_LSB  = 0;  // 3:0
    localparam int TEST_SEL_LSB   = 4;  // 5:4
    localparam int TEST_EN_BIT    = 6;
    localparam int TEST_PASS_BIT  = 8;
    localparam int TEST_M8_BIT    = 9;
    localparam int TEST_M9_BIT    = 10;
    localparam int TEST_DONE_BIT  = 15;
    localparam logic [1:0] TEST_SEL_RSVD = 2'h3;

    // Event status and mask word
    localparam int EVT_STAT_LSB   = 0;  // 2:0, write one to clear
    localparam int EVT_MASK_LSB   = 16; // 18:16

    // Reset values
    localparam logic [1:0]  THR_RST      = 2'h0;
    localparam logic [2:0]  EVT_MASK_RST = 3'h7;
    localparam logic [3:0]  TEST_ITEM_RST = 4'h0;
    localparam logic [11:0] RESULT_RST   = 12'h000;

    // Trip points in degrees, result code read as whole degrees
    localparam logic [11:0] TRIP_00 = 12'h06E; // 110
    localparam logic [11:0] TRIP_01 = 12'h078; // 120
    localparam logic [11:0] TRIP_10 = 12'h082; // 130
    localparam logic [11:0] TRIP_11 = 12'h08C; // 140

    // Burst conversion period
    localparam int CLK_MHZ         = 100;
    localparam int BURST_PERIOD_US = 1000;
    localparam int BURST_CYC       = BURST_PERIOD_US * CLK_MHZ;
endpackage

// ===== rtl/tsm_monitor.sv
// Thermal sensor monitor: conversion control, thresholds, events, digital test
`timescale 1ns/10ps
module tsm_monitor #(
    parameter int BURST_CYC = tsm_pkg::BURST_CYC  // Cycles between burst conversions
) (
    input  wire logic        clk_i,          // Core clock, 100 MHz
    input  wire logic        rst_i,          // Synchronous reset, active high
    input  wire logic        cfg_wr_i,       // Register write strobe
    input  wire logic        cfg_rd_i,       // Register read strobe
    input  wire logic [11:0] cfg_addr_i,     // Register byte offset
    input  wire logic [31:0] cfg_wdata_i,    // Write data
    output logic      [31:0] cfg_rdata_o,    // Read data, registered
    output logic             cfg_ack_o,      // Access done pulse
    output logic             sens_pd_o,      // Sensor power down
    output logic             sens_start_o,   // Conversion request level
    input  wire logic        sens_done_i,    // Conversion done from sensor
    input  wire logic [11:0] sens_t0_i,      // Sensor 0 result
    input  wire logic [11:0] sens_t1_i,      // Sensor 1 result
    input  wire logic [11:0] sens_t2_i,      // Sensor 2 result
    output logic             dtest_en_o,     // Digital test enable
    output logic      [3:0]  dtest_item_o,   // Test item select
    output logic      [1:0]  dtest_sel_o,    // Sensor under test
    input  wire logic [3:0]  dtest_stat_i,   // {done, mode9, mode8, pass}
    output logic             therm_evt_o     // Unmasked thermal event
);
    typedef enum logic {ST_IDLE, ST_CONV} tsm_state_t;

    tsm_state_t  state_r;
    tsm_state_t  state_nxt;
    logic [1:0]  thr_r [3];
    logic        auto_r;
    logic        burst_r;
    logic        single_r;
    logic        pd_r;
    logic        single_pend_r;
    logic        conv_done_r;
    logic [11:0] res_r [3];
    logic [2:0]  over_r;
    logic [2:0]  evt_r;
    logic [2:0]  mask_r;
    logic [3:0]  item_r;
    logic [1:0]  sel_r;
    logic        test_en_r;
    logic [19:0] per_cnt_r;
    logic        burst_tick_r;
    logic        done_s1_r;
    logic        done_s2_r;
    logic        done_s3_r;
    logic [35:0] dat_s1_r;
    logic [35:0] dat_s2_r;
    logic [3:0]  dts_s1_r;
    logic [3:0]  dts_s2_r;

    // Address decode
    wire wr_thr  = cfg_wr_i && (cfg_addr_i == tsm_pkg::OFF_THR_STAT);
    wire wr_evt  = cfg_wr_i && (cfg_addr_i == tsm_pkg::OFF_EVT_MASK);
    wire wr_test = cfg_wr_i && (cfg_addr_i == tsm_pkg::OFF_TEST_CTRL);
    wire wr_conv = cfg_wr_i && (cfg_addr_i == tsm_pkg::OFF_CONV_CTRL);

    // Trip point lookup and compare per sensor
    logic [11:0] trip [3];
    logic [2:0]  over_cmp;
    for (genvar g = 0; g < 3; g++) begin : g_cmp
        assign trip[g] = (thr_r[g] == 2'h0) ? tsm_pkg::TRIP_00 :
                         (thr_r[g] == 2'h1) ? tsm_pkg::TRIP_01 :
                         (thr_r[g] == 2'h2) ? tsm_pkg::TRIP_10 : tsm_pkg::TRIP_11;
        assign over_cmp[g] = res_r[g] > trip[g];
    end
    wire [2:0] over_rise = over_cmp & ~over_r;

    wire done_edge  = done_s2_r && !done_s3_r;
    wire periodic   = burst_r || auto_r;
    wire launch     = (state_r == ST_IDLE) && !pd_r && (single_pend_r || burst_tick_r);
    wire conv_fin   = (state_r == ST_CONV) && done_edge;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: if (launch) state_nxt = ST_CONV;
            ST_CONV: if (done_edge || pd_r) state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    assign sens_start_o = (state_r == ST_CONV) && !pd_r;
    assign sens_pd_o    = pd_r;
    assign dtest_en_o   = test_en_r && (sel_r != tsm_pkg::TEST_SEL_RSVD);
    assign dtest_item_o = item_r;
    assign dtest_sel_o  = sel_r;
    assign therm_evt_o  = |(evt_r & ~mask_r);

    // Read data words
    wire [31:0] rd_thr  = {auto_r, 1'b0, thr_r[2], thr_r[1], thr_r[0], 21'h0, over_r};
    wire [31:0] rd_evt  = {13'h0, mask_r, 13'h0, evt_r};
    wire [31:0] rd_conv = {8'h0, conv_done_r, 3'h0, res_r[0], 5'h0, pd_r, single_r, burst_r};
    wire [31:0] rd_test = {16'h0, dts_s2_r[3], 4'h0, dts_s2_r[2:0], 1'b0, test_en_r, sel_r,
                           item_r};
    wire [31:0] rd_mux  = (cfg_addr_i == tsm_pkg::OFF_THR_STAT)  ? rd_thr  :
                          (cfg_addr_i == tsm_pkg::OFF_EVT_MASK)  ? rd_evt  :
                          (cfg_addr_i == tsm_pkg::OFF_CONV_CTRL) ? rd_conv :
                          (cfg_addr_i == tsm_pkg::OFF_TEST_CTRL) ? rd_test : 32'h0;

    // Bus answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_ack_o   <= 1'b0;
            cfg_rdata_o <= 32'h0;
        end else begin
            cfg_ack_o <= cfg_wr_i || cfg_rd_i;
            if (cfg_rd_i) cfg_rdata_o <= rd_mux;
        end
    end

    // Synchronisers for sensor and test macro outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_s1_r <= 1'b0;
            done_s2_r <= 1'b0;
            done_s3_r <= 1'b0;
            dat_s1_r  <= 36'h0;
            dat_s2_r  <= 36'h0;
            dts_s1_r  <= 4'h0;
            dts_s2_r  <= 4'h0;
        end else begin
            done_s1_r <= sens_done_i;
            done_s2_r <= done_s1_r;
            done_s3_r <= done_s2_r;
            dat_s1_r  <= {sens_t2_i, sens_t1_i, sens_t0_i};
            dat_s2_r  <= dat_s1_r;
            dts_s1_r  <= dtest_stat_i;
            dts_s2_r  <= dts_s1_r;
        end
    end

    // Software controls
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thr_r     <= '{default: tsm_pkg::THR_RST};
            auto_r    <= 1'b0;
            burst_r   <= 1'b0;
            single_r  <= 1'b0;
            pd_r      <= 1'b0;
            mask_r    <= tsm_pkg::EVT_MASK_RST;
            item_r    <= tsm_pkg::TEST_ITEM_RST;
            sel_r     <= 2'h0;
            test_en_r <= 1'b0;
        end else begin
            if (wr_thr) begin
                thr_r[0] <= cfg_wdata_i[tsm_pkg::THR_FLD0_LSB +: 2];
                thr_r[1] <= cfg_wdata_i[tsm_pkg::THR_FLD1_LSB +: 2];
                thr_r[2] <= cfg_wdata_i[tsm_pkg::THR_FLD2_LSB +: 2];
                auto_r   <= cfg_wdata_i[tsm_pkg::THR_AUTO_BIT];
            end
            if (wr_conv) begin
                burst_r  <= cfg_wdata_i[tsm_pkg::CONV_BURST_BIT];
                single_r <= cfg_wdata_i[tsm_pkg::CONV_SINGLE_BIT];
                pd_r     <= cfg_wdata_i[tsm_pkg::CONV_PD_BIT];
            end
            if (wr_evt) mask_r <= cfg_wdata_i[tsm_pkg::EVT_MASK_LSB +: 3];
            if (wr_test) begin
                item_r    <= cfg_wdata_i[tsm_pkg::TEST_ITEM_LSB +: 4];
                sel_r     <= cfg_wdata_i[tsm_pkg::TEST_SEL_LSB +: 2];
                test_en_r <= cfg_wdata_i[tsm_pkg::TEST_EN_BIT];
            end
        end
    end

    // Burst period; the first periodic conversion waits one full period
    always_ff @(posedge clk_i) begin
        if (rst_i || !periodic) begin
            per_cnt_r    <= 20'h0;
            burst_tick_r <= 1'b0;
        end else begin
            if (per_cnt_r == 20'(BURST_CYC - 1)) begin
                per_cnt_r    <= 20'h0;
                burst_tick_r <= 1'b1;
            end else begin
                per_cnt_r <= per_cnt_r + 20'h1;
                if (launch) burst_tick_r <= 1'b0;
            end
        end
    end

    // Conversion sequencing and result capture
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r       <= ST_IDLE;
            single_pend_r <= 1'b0;
            conv_done_r   <= 1'b0;
            res_r         <= '{default: tsm_pkg::RESULT_RST};
            over_r        <= 3'h0;
            evt_r         <= 3'h0;
        end else begin
            state_r <= state_nxt;
            // A new single request wins over the launch that consumes the old one
            if (wr_conv && cfg_wdata_i[tsm_pkg::CONV_SINGLE_BIT])
                single_pend_r <= 1'b1;
            else if (launch)
                single_pend_r <= 1'b0;
            if (launch) conv_done_r <= 1'b0;
            else if (conv_fin) conv_done_r <= 1'b1;
            if (conv_fin) begin
                res_r[0] <= dat_s2_r[11:0];
                res_r[1] <= dat_s2_r[23:12];
                res_r[2] <= dat_s2_r[35:24];
            end
            over_r <= over_cmp;
            // Set wins over a same-cycle write-one clear
            evt_r  <= (evt_r & ~(wr_evt ? cfg_wdata_i[tsm_pkg::EVT_STAT_LSB +: 3] : 3'h0))
                      | over_rise;
        end
    end

    // Checks
    done_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        launch |=> !conv_done_r && (state_r == ST_CONV))
        else $error("done flag not cleared at conversion start");
    result_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !conv_fin |=> $stable(res_r[0]) && (conv_done_r || !$past(conv_done_r)
        || $past(launch)))
        else $error("result changed without a completed conversion");
    done_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        conv_fin |=> conv_done_r && res_r[0] == $past(dat_s2_r[11:0]))
        else $error("result or done not updated on completion");
    pd_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
        pd_r |-> !sens_start_o && sens_pd_o ##1 (state_r == ST_IDLE))
        else $error("conversion active while powered down");
    single_go_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_conv && cfg_wdata_i[1] && !cfg_wdata_i[2] && state_r == ST_IDLE)
        |=> ##[0:1] sens_start_o)
        else $error("single request did not start a conversion");
    evt_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
        over_rise[0] |=> evt_r[0])
        else $error("event bit lost");
    over_cmp_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (res_r[1] > trip[1]) ##1 (res_r[1] > trip[1]) |-> over_r[1])
        else $error("over-threshold status wrong");
    mask_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (mask_r == 3'h7) |-> !therm_evt_o)
        else $error("masked event reached output");
    // Checked only on the first edge after release; the very first edge still sees unreset flops
    reset_val_a: assert property (@(posedge clk_i)
        $past(rst_i) && !rst_i
        |-> thr_r[2] == 2'h0 && !auto_r && mask_r == 3'h7 && res_r[0] == 12'h0)
        else $error("bad reset value");
    sel_rsvd_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (sel_r == 2'h3) |-> !dtest_en_o)
        else $error("test enabled on reserved select");

    conv_cov_c:  cover property (@(posedge clk_i) disable iff (rst_i) launch ##[1:20] conv_fin);
    burst_cov_c: cover property (@(posedge clk_i) disable iff (rst_i)
        periodic && burst_tick_r && launch);
    evt_cov_c:   cover property (@(posedge clk_i) disable iff (rst_i) therm_evt_o);
    test_cov_c:  cover property (@(posedge clk_i) disable iff (rst_i) dtest_en_o && dts_s2_r[3]);
endmodule

// ===== testbench/test_tsm_monitor.sv
// Self-checking bench for the thermal sensor monitor register and sensor interfaces
`timescale 1ns/10ps
module test_tsm_monitor;
    localparam int BCYC = 30;
    typedef struct packed { logic chk; logic [31:0] exp; } tsm_note_t;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cfg_wr_i = 1'b0;
    logic        cfg_rd_i = 1'b0;
    logic [11:0] cfg_addr_i = 12'h000;
    logic [31:0] cfg_wdata_i = 32'h0;
    logic [31:0] cfg_rdata_o;
    logic        cfg_ack_o, sens_pd_o, sens_start_o, dtest_en_o, therm_evt_o;
    logic        sens_done_i = 1'b0;
    logic [11:0] sens_t0_i = 12'h000, sens_t1_i = 12'h000, sens_t2_i = 12'h000;
    logic [3:0]  dtest_item_o;
    logic [1:0]  dtest_sel_o;
    logic [3:0]  dtest_stat_i = 4'h0;
    logic [31:0] seed = 32'd93830;
    tsm_note_t   notes[$];
    tsm_note_t   mn;
    int          err_total = 0;
    int          check_count = 0;

    tsm_monitor #(.BURST_CYC(BCYC)) dut (.clk_i(clk_i), .rst_i(rst_i), .cfg_wr_i(cfg_wr_i),
        .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i),
        .cfg_rdata_o(cfg_rdata_o), .cfg_ack_o(cfg_ack_o), .sens_pd_o(sens_pd_o),
        .sens_start_o(sens_start_o), .sens_done_i(sens_done_i), .sens_t0_i(sens_t0_i),
        .sens_t1_i(sens_t1_i), .sens_t2_i(sens_t2_i), .dtest_en_o(dtest_en_o),
        .dtest_item_o(dtest_item_o), .dtest_sel_o(dtest_sel_o), .dtest_stat_i(dtest_stat_i),
        .therm_evt_o(therm_evt_o));

    always #5 clk_i = ~clk_i;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic close_out();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check_val(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One access per call; strobe drops on the taking edge so accesses never merge
    task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic chk, input logic [31:0] e);
        tsm_note_t n;
        n.chk = chk;
        n.exp = e;
        @(posedge clk_i);
        notes.push_back(n);
        cfg_wr_i    <= wr;
        cfg_rd_i    <= ~wr;
        cfg_addr_i  <= a;
        cfg_wdata_i <= d;
        @(posedge clk_i);
        cfg_wr_i <= 1'b0;
        cfg_rd_i <= 1'b0;
    endtask

    // Every acknowledge consumes exactly one note, so a missing or extra ack is caught
    always @(posedge clk_i) begin
        if (cfg_ack_o === 1'b1) begin
            if (notes.size() == 0) check_val("cfg_ack_o unexpected", 1'b1, 1'b0);
            else begin
                mn = notes.pop_front();
                if (mn.chk) check_val("cfg_rdata_o", cfg_rdata_o, mn.exp);
            end
        end
    end

    task automatic wait_lvl(input logic lvl, input int bound);
        int k;
        k = 0;
        while (sens_start_o !== lvl && k < bound) begin
            @(posedge clk_i);
            k++;
        end
        if (sens_start_o !== lvl) begin
            check_val("sens_start_o wait", sens_start_o, lvl);
            close_out();
        end
    endtask

    // Sensor side answers a running conversion; results settle well before done
    task automatic answer(input logic [11:0] t0, input logic [11:0] t1, input logic [11:0] t2);
        sens_t0_i <= t0;
        sens_t1_i <= t1;
        sens_t2_i <= t2;
        repeat (4) @(posedge clk_i);
        sens_done_i <= 1'b1;
        wait_lvl(1'b0, 10);
        sens_done_i <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask

    initial begin
        #(500000);
        check_val("run time limit", 1'b1, 1'b0);
        close_out();
    end

    initial begin
        logic [11:0] addrs[5];
        logic [31:0] rsts[5];
        logic [31:0] w, thr;
        logic [11:0] t0, t1, t2, trip;
        logic [3:0]  st;
        logic [2:0]  over, prev, ev;
        int          hi;
        addrs = '{12'h538, 12'h53C, 12'h5D4, 12'h5D8, 12'h5DC};
        rsts  = '{32'h00070000, 32'h0, 32'h0, 32'h0, 32'h0};
        t0    = 12'h000;
        t1    = 12'h000;
        t2    = 12'h000;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        acc(1'b1, 12'h5DC, 32'hFFFFFFFF, 1'b0, 32'h0);
        foreach (addrs[i]) acc(1'b0, addrs[i], 32'h0, 1'b1, rsts[i]);
        for (int i = 0; i < 8; i++) begin
            st = xs();
            dtest_stat_i <= st;
            w = xs();
            w[5:4] = i % 4;
            repeat (3) @(posedge clk_i);
            acc(1'b1, tsm_pkg::OFF_TEST_CTRL, w, 1'b0, 32'h0);
            acc(1'b0, tsm_pkg::OFF_TEST_CTRL, 32'h0, 1'b1, (w & 32'h7F) | {16'h0, st[3], 4'h0,
                st[2:0], 8'h00});
            check_val("dtest_en_o", dtest_en_o, w[6] && (w[5:4] != 2'h3));
            check_val("dtest_sel_o", dtest_sel_o, w[5:4]);
            check_val("dtest_item_o", dtest_item_o, w[3:0]);
        end
        // Burst via the run bit, then via the automatic threshold bit; zero results keep status clear
        for (int k = 0; k < 2; k++) begin
            acc(1'b1, k ? tsm_pkg::OFF_THR_STAT : tsm_pkg::OFF_CONV_CTRL, k ? 32'h80000000 : 32'h1,
                1'b0, 32'h0);
            repeat (2) begin
                wait_lvl(1'b1, BCYC + 10);
                answer(12'h000, 12'h000, 12'h000);
            end
            acc(1'b1, k ? tsm_pkg::OFF_THR_STAT : tsm_pkg::OFF_CONV_CTRL, 32'h0, 1'b0, 32'h0);
            hi = 0;
            repeat (3 * BCYC) begin
                @(posedge clk_i);
                if (sens_start_o !== 1'b0) hi++;
            end
            check_val("start after burst off", hi, 0);
        end
        acc(1'b1, tsm_pkg::OFF_EVT_MASK, 32'h00060000, 1'b0, 32'h0);
        for (int c = 0; c < 4; c++) begin
            trip = 12'd110 + 12'd10 * c;
            // The new trip point is judged against the old results first; events need a rise
            prev = {t2 > trip, t1 > trip, t0 > trip};
            t0 = trip + 12'd1;
            t1 = trip;
            t2 = trip - 12'd2 + xs() % 5;
            thr = {2'b00, c[1:0], c[1:0], c[1:0], 24'h0};
            acc(1'b1, tsm_pkg::OFF_THR_STAT, thr | 32'h40FFFFFF, 1'b0, 32'h0);
            acc(1'b1, tsm_pkg::OFF_CONV_CTRL, 32'h2, 1'b0, 32'h0);
            wait_lvl(1'b1, 10);
            answer(t0, t1, t2);
            over = {t2 > trip, t1 > trip, t0 > trip};
            ev = over & ~prev;
            acc(1'b0, tsm_pkg::OFF_CONV_CTRL, 32'h0, 1'b1, 32'h00800002 | {t0, 8'h00});
            acc(1'b0, tsm_pkg::OFF_THR_STAT, 32'h0, 1'b1, thr | over);
            acc(1'b0, tsm_pkg::OFF_EVT_MASK, 32'h0, 1'b1, 32'h00060000 | ev);
            check_val("therm_evt_o", therm_evt_o, ev[0]);
            check_val("single run once", sens_start_o, 1'b0);
            acc(1'b1, tsm_pkg::OFF_EVT_MASK, 32'h00060007, 1'b0, 32'h0);
            @(posedge clk_i);
            check_val("therm_evt_o cleared", therm_evt_o, 1'b0);
        end
        acc(1'b1, tsm_pkg::OFF_CONV_CTRL, 32'hFFFFFFFE, 1'b0, 32'h0);
        repeat (5) @(posedge clk_i);
        check_val("sens_pd_o", sens_pd_o, 1'b1);
        check_val("sens_start_o in power down", sens_start_o, 1'b0);
        acc(1'b0, tsm_pkg::OFF_CONV_CTRL, 32'h0, 1'b1, 32'h00800006 | {t0, 8'h00});
        repeat (4) @(posedge clk_i);
        check_val("notes left", notes.size(), 0);
        close_out();
    end
endmodule
